// *** outdrv_pkg.sv ***
// Purpose: Shared constants and carriers for the output driver protection block
// Assumes: Byte-wide register port, page select held by the caller
// Notes:   Offsets are register numbers within a page

package outdrv_pkg;

  localparam logic [7:0] hp_ctrl_offset     = 8'h1f;
  localparam logic [7:0] spk_ctrl_offset    = 8'h20;
  localparam logic [7:0] hp_gain_offset     = 8'h28;
  localparam logic [7:0] spk_gain_offset    = 8'h2a;
  localparam logic [7:0] drive_mode_offset  = 8'h2c;
  localparam logic [7:0] page_zero          = 8'h00;
  localparam logic [7:0] page_one           = 8'h01;

  localparam int         power_bit          = 7;
  localparam int         hp_shutdown_bit    = 1;
  localparam int         fault_bit          = 0;
  localparam int         cm_lsb             = 3;
  localparam int         hp_gain_lsb        = 3;
  localparam int         spk_gain_lsb       = 3;
  localparam int         spk_mute_bit       = 2;
  localparam int         lineout_lsb        = 1;
  localparam logic [1:0] lineout_low_power  = 2'h3;

  localparam logic [7:0] hp_ctrl_reset      = 8'h00;
  localparam logic [7:0] spk_ctrl_reset     = 8'h00;
  localparam logic [7:0] hp_gain_reset      = 8'h00;
  localparam logic [7:0] spk_gain_reset     = 8'h00;
  localparam logic [7:0] drive_mode_reset   = 8'h00;
  localparam logic [7:0] zero_byte          = 8'h00;

  typedef enum logic [1:0] {src_left, src_right, src_mix, src_mute} mix_sel_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       hp_power;
    logic       hp_current_limit;
    logic [1:0] hp_common_mode;
    logic [3:0] hp_gain;
    logic       hp_lineout_low_power;
    logic       spk_power;
    logic [1:0] spk_gain;
    logic       spk_mute;
  } drive_ctrl_t;

endpackage : outdrv_pkg

// *** output_driver_protection_ctrl.sv ***
// Purpose: Control registers and short-circuit protection for headphone and speaker drivers
// Assumes: Fault detect inputs come from analog comparators, asynchronous to core_clk
// Notes:   Fault flags are read-only; a write to them is dropped
// Operation
// [RULE1] Field 11 selects low-power lineout drive
// [RULE2] Two-bit field selects output common mode
// [RULE3] Headphone power bit powers driver up
// [RULE4] Four-bit field sets headphone gain
// [RULE5] Shutdown bit chooses limit or power-down
// [RULE6] Reset default is current limiting
// [RULE7] Headphone short sets read-only fault flag
// [RULE8] Shutdown mode clears headphone power bit
// [RULE9] Setting power bit again re-enables headphone
// [RULE10] Master reset restores all defaults
// [RULE11] Persistent short shuts stage down again
// [RULE12] Software limits retries to three
// [RULE13] Speaker power bit powers driver up
// [RULE14] Speaker gain field and mute bit
// [RULE15] Speaker overcurrent always shuts down
// [RULE16] Speaker shutdown sets read-only fault flag
// [RULE17] Setting speaker power bit re-enables it
// [RULE18] Either or both channels feed speaker; code always selects both (src_mix) unless muted
// [RULE19] Fault flag held until re-enable or reset

`timescale 1ns/1ps

module output_driver_protection_ctrl (
  input  wire logic                  core_clk,      // Register clock, 200 MHz
  input  wire logic                  rst,           // Pin reset, async, active high
  input  wire logic                  sw_reset,      // Software reset pulse, same clock
  input  wire outdrv_pkg::reg_req_t  req,           // Register access request
  input  wire logic                  hp_short_det,  // Headphone short comparator, async
  input  wire logic                  spk_short_det, // Speaker overcurrent comparator, async
  output logic [7:0]                 rdata,         // Read data, valid cycle after read
  output logic                       rvalid,        // Read data strobe
  output outdrv_pkg::drive_ctrl_t    drive,         // Analog driver controls
  output logic                       hp_limiting,   // Headphone current limit active
  output outdrv_pkg::mix_sel_t       spk_mix_sel    // Speaker channel mixing select
);

  typedef struct packed {
    logic       hp_sync1;
    logic       hp_sync2;
    logic       spk_sync1;
    logic       spk_sync2;
    logic       hp_power;
    logic       hp_shutdown_mode;
    logic       hp_fault;
    logic [1:0] hp_cm;
    logic [7:0] hp_gain_reg;
    logic [7:0] spk_gain_reg;
    logic       spk_power;
    logic       spk_fault;
    logic [7:0] mode_reg;
    logic [7:0] rdata;
    logic       rvalid;
    logic       limiting;
    outdrv_pkg::drive_ctrl_t drive;
    outdrv_pkg::mix_sel_t    mix;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic hit(input outdrv_pkg::reg_req_t r, input logic [7:0] pg, input logic [7:0] off);
    hit = (r.page == pg) && (r.addr == off);
  endfunction : hit

  logic hp_short;
  logic spk_short;
  logic hp_ctrl_wr;
  logic spk_ctrl_wr;
  logic mode_wr;
  logic [7:0] hp_ctrl_view;
  logic [7:0] spk_ctrl_view;

  assign hp_short    = st.hp_sync2;
  assign spk_short   = st.spk_sync2;
  assign hp_ctrl_wr  = req.write && hit(req, outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset);
  assign spk_ctrl_wr = req.write && hit(req, outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset);
  assign mode_wr     = req.write && hit(req, outdrv_pkg::page_zero, outdrv_pkg::drive_mode_offset);

  always_comb begin
    hp_ctrl_view = outdrv_pkg::zero_byte;
    hp_ctrl_view[outdrv_pkg::power_bit] = st.hp_power;
    hp_ctrl_view[outdrv_pkg::cm_lsb +: 2] = st.hp_cm;
    hp_ctrl_view[outdrv_pkg::hp_shutdown_bit] = st.hp_shutdown_mode;
    hp_ctrl_view[outdrv_pkg::fault_bit] = st.hp_fault;
    spk_ctrl_view = outdrv_pkg::zero_byte;
    spk_ctrl_view[outdrv_pkg::power_bit] = st.spk_power;
    spk_ctrl_view[outdrv_pkg::fault_bit] = st.spk_fault;
  end

  always_comb begin
    next_st = st;
    next_st.hp_sync1 = hp_short_det;
    next_st.hp_sync2 = st.hp_sync1;
    next_st.spk_sync1 = spk_short_det;
    next_st.spk_sync2 = st.spk_sync1;
    next_st.rvalid = 1'b0;

    if (req.write && hit(req, outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset)) begin
      next_st.hp_cm = req.wdata[outdrv_pkg::cm_lsb +: 2]; // RULE2
      next_st.hp_shutdown_mode = req.wdata[outdrv_pkg::hp_shutdown_bit]; // RULE5
      next_st.hp_power = req.wdata[outdrv_pkg::power_bit]; // RULE3
      // Rising power write is the stage reset; fault cleared, re-raised if short remains
      if (req.wdata[outdrv_pkg::power_bit] && !st.hp_power) begin
        next_st.hp_fault = 1'b0; // RULE9 RULE19
      end
    end
    if (spk_ctrl_wr) begin
      next_st.spk_power = req.wdata[outdrv_pkg::power_bit]; // RULE13
      if (req.wdata[outdrv_pkg::power_bit] && !st.spk_power) begin
        next_st.spk_fault = 1'b0; // RULE17 RULE19
      end
    end
    if (req.write && hit(req, outdrv_pkg::page_one, outdrv_pkg::hp_gain_offset)) begin
      next_st.hp_gain_reg = req.wdata; // RULE4
    end
    if (req.write && hit(req, outdrv_pkg::page_one, outdrv_pkg::spk_gain_offset)) begin
      next_st.spk_gain_reg = req.wdata; // RULE14
    end
    if (mode_wr) begin
      next_st.mode_reg = req.wdata; // RULE1
    end

    // Short detection beats a same-cycle software write, so no event is lost
    next_st.limiting = 1'b0;
    if (hp_short && st.hp_power) begin
      next_st.hp_fault = 1'b1; // RULE7
      if (st.hp_shutdown_mode) begin
        next_st.hp_power = 1'b0; // RULE8 RULE11
      end else begin
        next_st.limiting = 1'b1; // RULE5
      end
    end
    if (spk_short && st.spk_power) begin
      next_st.spk_fault = 1'b1; // RULE16
      next_st.spk_power = 1'b0; // RULE15 RULE11
    end

    if (req.read) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = outdrv_pkg::zero_byte;
      if (hit(req, outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset)) next_st.rdata = hp_ctrl_view;
      if (hit(req, outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset)) next_st.rdata = spk_ctrl_view;
      if (hit(req, outdrv_pkg::page_one, outdrv_pkg::hp_gain_offset)) next_st.rdata = st.hp_gain_reg;
      if (hit(req, outdrv_pkg::page_one, outdrv_pkg::spk_gain_offset)) next_st.rdata = st.spk_gain_reg;
      if (hit(req, outdrv_pkg::page_zero, outdrv_pkg::drive_mode_offset)) next_st.rdata = st.mode_reg;
    end

    next_st.drive.hp_power = next_st.hp_power;
    next_st.drive.hp_current_limit = !next_st.hp_shutdown_mode;
    next_st.drive.hp_common_mode = next_st.hp_cm;
    next_st.drive.hp_gain = next_st.hp_gain_reg[outdrv_pkg::hp_gain_lsb +: 4];
    next_st.drive.hp_lineout_low_power =
      (next_st.mode_reg[outdrv_pkg::lineout_lsb +: 2] == outdrv_pkg::lineout_low_power); // RULE1
    next_st.drive.spk_power = next_st.spk_power;
    next_st.drive.spk_gain = next_st.spk_gain_reg[outdrv_pkg::spk_gain_lsb +: 2];
    next_st.drive.spk_mute = next_st.spk_gain_reg[outdrv_pkg::spk_mute_bit]; // RULE14
    // Both channels summed feed the mono speaker; swap handled upstream by channel select
    next_st.mix = next_st.drive.spk_mute ? outdrv_pkg::src_mute : outdrv_pkg::src_mix; // RULE18

    if (sw_reset) begin
      next_st = '0; // RULE10
      next_st.mix = outdrv_pkg::src_mix;
      next_st.drive.hp_current_limit = 1'b1; // RULE6
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0; // RULE10 RULE6
      st.mix <= outdrv_pkg::src_mix;
      st.drive.hp_current_limit <= 1'b1; // RULE6
    end else begin
      st <= next_st;
    end
  end

  assign rdata       = st.rdata;
  assign rvalid      = st.rvalid;
  assign drive       = st.drive;
  assign hp_limiting = st.limiting;
  assign spk_mix_sel = st.mix;

  property p_hp_shutdown;
    @(posedge core_clk) disable iff (rst)
      (hp_short && st.hp_power && st.hp_shutdown_mode && !hp_ctrl_wr && !sw_reset)
        |=> (!st.hp_power && st.hp_fault && !drive.hp_power);
  endproperty
  a_hp_shutdown: assert property (p_hp_shutdown) else $error("headphone did not shut down"); // RULE8

  property p_hp_limit;
    @(posedge core_clk) disable iff (rst)
      (hp_short && st.hp_power && !st.hp_shutdown_mode && !hp_ctrl_wr && !sw_reset)
        |=> (st.hp_power && hp_limiting && st.hp_fault);
  endproperty
  a_hp_limit: assert property (p_hp_limit) else $error("headphone did not limit"); // RULE5

  property p_spk_shutdown;
    @(posedge core_clk) disable iff (rst)
      (spk_short && st.spk_power && !spk_ctrl_wr && !sw_reset) |=> (!st.spk_power && st.spk_fault);
  endproperty
  a_spk_shutdown: assert property (p_spk_shutdown) else $error("speaker did not shut down"); // RULE15

  property p_spk_fault_hold;
    @(posedge core_clk) disable iff (rst)
      (st.spk_fault && !spk_ctrl_wr && !sw_reset) |=> st.spk_fault;
  endproperty
  a_spk_fault_hold: assert property (p_spk_fault_hold) else $error("speaker fault dropped"); // RULE19

  property p_sw_reset;
    @(posedge core_clk) disable iff (rst)
      sw_reset |=> (!st.hp_power && !st.spk_power && !st.hp_fault && !st.spk_fault && !st.hp_shutdown_mode
        && drive.hp_current_limit);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset incomplete"); // RULE10

  property p_lineout;
    @(posedge core_clk) disable iff (rst)
      (mode_wr && !sw_reset && req.wdata[2:1] == 2'h3) |=> drive.hp_lineout_low_power;
  endproperty
  a_lineout: assert property (p_lineout) else $error("lineout mode not applied"); // RULE1

  property p_spk_reenable;
    @(posedge core_clk) disable iff (rst)
      (spk_ctrl_wr && req.wdata[7] && !st.spk_power && !sw_reset) |=> (st.spk_power && !st.spk_fault);
  endproperty
  a_spk_reenable: assert property (p_spk_reenable) else $error("speaker re-enable failed"); // RULE17

  property p_hp_gain;
    @(posedge core_clk) disable iff (rst)
      (req.write && hit(req, 8'h01, 8'h28) && !sw_reset) |=> ##1 (drive.hp_gain == $past(req.wdata[6:3], 2));
  endproperty
  a_hp_gain: assert property (p_hp_gain) else $error("headphone gain mismatch"); // RULE4

  property p_hp_power_write;
    @(posedge core_clk) disable iff (rst)
      (hp_ctrl_wr && !sw_reset && !(hp_short && st.hp_power && st.hp_shutdown_mode))
        |=> (drive.hp_power == $past(req.wdata[outdrv_pkg::power_bit]));
  endproperty
  a_hp_power_write: assert property (p_hp_power_write) else $error("headphone power bit not applied"); // RULE3

  property p_hp_cm;
    @(posedge core_clk) disable iff (rst)
      (hp_ctrl_wr && !sw_reset)
        |=> (drive.hp_common_mode == $past(req.wdata[outdrv_pkg::cm_lsb +: 2]));
  endproperty
  a_hp_cm: assert property (p_hp_cm) else $error("common mode not applied"); // RULE2

  property p_hp_mode_bit;
    @(posedge core_clk) disable iff (rst)
      (hp_ctrl_wr && !sw_reset)
        |=> (drive.hp_current_limit == !$past(req.wdata[outdrv_pkg::hp_shutdown_bit]));
  endproperty
  a_hp_mode_bit: assert property (p_hp_mode_bit) else $error("short response mode not applied"); // RULE5

  property p_spk_power_write;
    @(posedge core_clk) disable iff (rst)
      (spk_ctrl_wr && !sw_reset && !(spk_short && st.spk_power))
        |=> (drive.spk_power == $past(req.wdata[outdrv_pkg::power_bit]));
  endproperty
  a_spk_power_write: assert property (p_spk_power_write) else $error("speaker power bit not applied"); // RULE13

  property p_spk_gain;
    @(posedge core_clk) disable iff (rst)
      (req.write && hit(req, outdrv_pkg::page_one, outdrv_pkg::spk_gain_offset) && !sw_reset)
        |=> (drive.spk_gain == $past(req.wdata[4:3]) && drive.spk_mute == $past(req.wdata[2]));
  endproperty
  a_spk_gain: assert property (p_spk_gain) else $error("speaker gain or mute mismatch"); // RULE14

  property p_hp_fault_set;
    @(posedge core_clk) disable iff (rst)
      (hp_short && st.hp_power && !sw_reset)
        |=> st.hp_fault;
  endproperty
  a_hp_fault_set: assert property (p_hp_fault_set) else $error("headphone fault not raised"); // RULE7

  property p_hp_fault_hold;
    @(posedge core_clk) disable iff (rst)
      (st.hp_fault && !hp_ctrl_wr && !sw_reset)
        |=> st.hp_fault;
  endproperty
  a_hp_fault_hold: assert property (p_hp_fault_hold) else $error("headphone fault dropped"); // RULE19

  property p_hp_reenable;
    @(posedge core_clk) disable iff (rst)
      (hp_ctrl_wr && req.wdata[7] && !st.hp_power && !sw_reset)
        |=> (st.hp_power && !st.hp_fault);
  endproperty
  a_hp_reenable: assert property (p_hp_reenable) else $error("headphone re-enable failed"); // RULE9

  property p_stage_keeps;
    @(posedge core_clk) disable iff (rst)
      ((hp_ctrl_wr || spk_ctrl_wr) && !sw_reset)
        |=> ($stable(st.hp_gain_reg) && $stable(st.spk_gain_reg) && $stable(st.mode_reg));
  endproperty
  a_stage_keeps: assert property (p_stage_keeps) else $error("stage reset touched other settings"); // RULE17

  property p_spk_set_wins;
    @(posedge core_clk) disable iff (rst)
      (spk_short && st.spk_power && !sw_reset)
        |=> (st.spk_fault && !drive.spk_power);
  endproperty
  a_spk_set_wins: assert property (p_spk_set_wins) else $error("speaker short lost to write"); // RULE16

  property p_hp_fault_ro;
    @(posedge core_clk) disable iff (rst)
      (hp_ctrl_wr && !st.hp_fault && !(hp_short && st.hp_power) && !sw_reset)
        |=> !st.hp_fault;
  endproperty
  a_hp_fault_ro: assert property (p_hp_fault_ro) else $error("headphone fault set by write"); // RULE7

  property p_hp_readback;
    @(posedge core_clk) disable iff (rst)
      (req.read && hit(req, outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset) && !sw_reset)
        |=> (rvalid && rdata[0] == $past(st.hp_fault) && rdata[7] == $past(st.hp_power));
  endproperty
  a_hp_readback: assert property (p_hp_readback) else $error("headphone status read wrong"); // RULE7

  property p_spk_readback;
    @(posedge core_clk) disable iff (rst)
      (req.read && hit(req, outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset) && !sw_reset)
        |=> (rvalid && rdata[0] == $past(st.spk_fault) && rdata[7] == $past(st.spk_power));
  endproperty
  a_spk_readback: assert property (p_spk_readback) else $error("speaker status read wrong"); // RULE16

  property p_limit_clears;
    @(posedge core_clk) disable iff (rst)
      !(hp_short && st.hp_power && !st.hp_shutdown_mode)
        |=> !hp_limiting;
  endproperty
  a_limit_clears: assert property (p_limit_clears) else $error("current limit left on"); // RULE5

  property p_lineout_off;
    @(posedge core_clk) disable iff (rst)
      (mode_wr && !sw_reset && req.wdata[2:1] != 2'h3)
        |=> !drive.hp_lineout_low_power;
  endproperty
  a_lineout_off: assert property (p_lineout_off) else $error("lineout mode left on"); // RULE1

  c_hp_shut: cover property (@(posedge core_clk) disable iff (rst) st.hp_power ##1 st.hp_fault && !st.hp_power);
  c_spk_shut: cover property (@(posedge core_clk) disable iff (rst) st.spk_power ##1 st.spk_fault);
  c_spk_retry: cover property (@(posedge core_clk) disable iff (rst) st.spk_fault ##1 st.spk_power);
  c_hp_limit: cover property (@(posedge core_clk) disable iff (rst) (hp_short && st.hp_power) ##1 hp_limiting);
  c_hp_retry: cover property (@(posedge core_clk) disable iff (rst) (st.hp_fault && !st.hp_power) ##1 st.hp_power);

endmodule : output_driver_protection_ctrl

// *** output_driver_protection_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the output driver protection block
// Assumes: Assertions live inside the design; fault inputs are driven as plain levels
// Notes:   Waits after a short cover the two-flop synchroniser plus one edge

`timescale 1ns/1ps

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module output_driver_protection_ctrl_tb_top;
  logic                    core_clk;
  logic                    rst;
  logic                    sw_reset;
  outdrv_pkg::reg_req_t    req;
  logic                    hp_short_det;
  logic                    spk_short_det;
  logic [7:0]              rdata;
  logic                    rvalid;
  outdrv_pkg::drive_ctrl_t drive;
  logic                    hp_limiting;
  outdrv_pkg::mix_sel_t    spk_mix_sel;
  int                      err_count;
  int                      tests_run;

  output_driver_protection_ctrl output_driver_protection_ctrl_inst (
    .core_clk      (core_clk),
    .rst           (rst),
    .sw_reset      (sw_reset),
    .req           (req),
    .hp_short_det  (hp_short_det),
    .spk_short_det (spk_short_det),
    .rdata         (rdata),
    .rvalid        (rvalid),
    .drive         (drive),
    .hp_limiting   (hp_limiting),
    .spk_mix_sel   (spk_mix_sel)
  );

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    req <= '{write: 1'b1, read: 1'b0, page: page, addr: addr, wdata: data};
    @(posedge core_clk);
    req.write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] expv);
    @(posedge core_clk);
    req <= '{write: 1'b0, read: 1'b1, page: page, addr: addr, wdata: 8'h00};
    @(posedge core_clk);
    req.read <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, expv)
  endtask : rd

  task automatic reset_values;
    `CHK(drive.hp_power, 1'b0)
    `CHK(drive.hp_current_limit, 1'b1)
    `CHK(hp_limiting, 1'b0)
    `CHK(spk_mix_sel, outdrv_pkg::src_mix)
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, outdrv_pkg::hp_ctrl_reset);
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, outdrv_pkg::spk_ctrl_reset);
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_gain_offset, outdrv_pkg::hp_gain_reset);
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_gain_offset, outdrv_pkg::spk_gain_reset);
    rd(outdrv_pkg::page_zero, outdrv_pkg::drive_mode_offset, outdrv_pkg::drive_mode_reset);
  endtask : reset_values

  task automatic fields;
    wr(outdrv_pkg::page_zero, outdrv_pkg::drive_mode_offset, 8'h06);
    `CHK(drive.hp_lineout_low_power, 1'b1)
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h99);
    `CHK(drive.hp_power, 1'b1)
    `CHK(drive.hp_common_mode, 2'h3)
    `CHK(drive.hp_current_limit, 1'b1)
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_gain_offset, 8'h50);
    `CHK(drive.hp_gain, 4'ha)
    wr(outdrv_pkg::page_one, outdrv_pkg::spk_gain_offset, 8'h14);
    `CHK(drive.spk_gain, 2'h2)
    `CHK(drive.spk_mute, 1'b1)
    `CHK(spk_mix_sel, outdrv_pkg::src_mute)
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h98);
    rd(outdrv_pkg::page_one, 8'h30, outdrv_pkg::zero_byte);
    wr(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h80);
    `CHK(drive.spk_power, 1'b1)
  endtask : fields

  task automatic hp_limit_mode;
    @(posedge core_clk);
    hp_short_det <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(hp_limiting, 1'b1)
    `CHK(drive.hp_power, 1'b1)
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h99);
    @(posedge core_clk);
    hp_short_det <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h99);
    `CHK(hp_limiting, 1'b0)
  endtask : hp_limit_mode

  task automatic hp_shutdown_mode;
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h8a);
    `CHK(drive.hp_current_limit, 1'b0)
    @(posedge core_clk);
    hp_short_det <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(drive.hp_power, 1'b0)
    `CHK(hp_limiting, 1'b0)
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h0b);
    // Retry while still shorted must trip again; two retries stay under the overheating limit
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h8a);
    repeat (6) @(posedge core_clk);
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h0b);
    @(posedge core_clk);
    hp_short_det <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h8a);
    repeat (6) @(posedge core_clk);
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h8a);
    rd(outdrv_pkg::page_one, outdrv_pkg::hp_gain_offset, 8'h50);
  endtask : hp_shutdown_mode

  task automatic spk_fault;
    @(posedge core_clk);
    spk_short_det <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(drive.spk_power, 1'b0)
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h01);
    wr(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h00);
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h01);
    wr(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h80);
    repeat (6) @(posedge core_clk);
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h01);
    @(posedge core_clk);
    spk_short_det <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h80);
    repeat (6) @(posedge core_clk);
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_ctrl_offset, 8'h80);
    rd(outdrv_pkg::page_one, outdrv_pkg::spk_gain_offset, 8'h14);
  endtask : spk_fault

  task automatic soft_reset;
    @(posedge core_clk);
    sw_reset <= 1'b1;
    @(posedge core_clk);
    sw_reset <= 1'b0;
    #1;
    `CHK(drive.spk_power, 1'b0)
    reset_values();
  endtask : soft_reset

  // Pin reset in mid-run, with a stage powered and settings changed
  task automatic pin_reset;
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_ctrl_offset, 8'h82);
    `CHK(drive.hp_power, 1'b1)
    `CHK(drive.hp_current_limit, 1'b0)
    wr(outdrv_pkg::page_one, outdrv_pkg::hp_gain_offset, 8'h50);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    reset_values();
  endtask : pin_reset

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    sw_reset = 1'b0;
    req = '0;
    hp_short_det = 1'b0;
    spk_short_det = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    reset_values();
    fields();
    hp_limit_mode();
    hp_shutdown_mode();
    spk_fault();
    soft_reset();
    pin_reset();
    tally_and_finish();
  end

  // Whole run is under two hundred cycles; this margin only catches a hang
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule : output_driver_protection_ctrl_tb_top
